// ### dv/capture_chk.sv
// Port-level checker for the counter capture block
`timescale 1ns/1ps
`default_nettype none
`include "capture_params.svh"

module capture_chk
  import capture_pkg::*;
#(
  parameter int COUNT_W = `COUNT_W,
  parameter int WORD_W  = `WORD_W
)
(
  input wire logic               clk,
  input wire logic               reset_n,
  input wire logic               edge_reverse_flag,
  input wire logic               interrupt_enable_op,
  input wire logic               interrupt_disable_op,
  input wire logic [COUNT_W-1:0] count_a,
  input wire logic [COUNT_W-1:0] count_b,
  input wire logic [WORD_W-1:0]  capture_a_high,
  input wire logic [WORD_W-1:0]  capture_a_low,
  input wire logic [WORD_W-1:0]  capture_b_high,
  input wire logic [WORD_W-1:0]  capture_b_low,
  input wire logic               capture_a_done,
  input wire logic               capture_b_done,
  input wire logic               falling_edge_active,
  input wire logic               isr_start,
  input wire isr_vector_t        isr_vector
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_fall_set;
    interrupt_enable_op && edge_reverse_flag && !interrupt_disable_op |=> falling_edge_active;
  endproperty
  a_fall_set: assert property (p_fall_set) else $error("polarity not reversed");
  property p_fall_clr;
    !edge_reverse_flag |=> !falling_edge_active;
  endproperty
  a_fall_clr: assert property (p_fall_clr) else $error("polarity not restored");
  property p_cap_a;
    capture_a_done |-> {capture_a_high, capture_a_low} == $past(count_a);
  endproperty
  a_cap_a: assert property (p_cap_a) else $error("pair a wrong value");
  property p_cap_b;
    capture_b_done |-> {capture_b_high, capture_b_low} == $past(count_b);
  endproperty
  a_cap_b: assert property (p_cap_b) else $error("pair b wrong value");
  property p_clr_a;
    capture_a_done |-> count_a <= 32'h0000_0001;
  endproperty
  a_clr_a: assert property (p_clr_a) else $error("count a not cleared");
  property p_clr_b;
    capture_b_done |-> count_b <= 32'h0000_0001;
  endproperty
  a_clr_b: assert property (p_clr_b) else $error("count b not cleared");
  // Whole-pair stability also catches a word written a cycle late
  property p_hold_a;
    !capture_a_done |-> $stable({capture_a_high, capture_a_low});
  endproperty
  a_hold_a: assert property (p_hold_a) else $error("pair a changed alone");
  property p_hold_b;
    !capture_b_done |-> $stable({capture_b_high, capture_b_low});
  endproperty
  a_hold_b: assert property (p_hold_b) else $error("pair b changed alone");
  property p_isr_after;
    capture_a_done || capture_b_done |=> isr_start ##0 $onehot(isr_vector);
  endproperty
  a_isr_after: assert property (p_isr_after) else $error("no routine after capture");
  property p_vec_idle;
    !isr_start |-> isr_vector == VEC_NONE;
  endproperty
  a_vec_idle: assert property (p_vec_idle) else $error("vector without start");
endmodule

bind counter_capture_on_interrupt capture_chk #(.COUNT_W(COUNT_W), .WORD_W(WORD_W)) u_chk
(
  .clk(clk), .reset_n(reset_n), .edge_reverse_flag(edge_reverse_flag),
  .interrupt_enable_op(interrupt_enable_op), .interrupt_disable_op(interrupt_disable_op),
  .count_a(count_a), .count_b(count_b),
  .capture_a_high(capture_a_high), .capture_a_low(capture_a_low),
  .capture_b_high(capture_b_high), .capture_b_low(capture_b_low),
  .capture_a_done(capture_a_done), .capture_b_done(capture_b_done),
  .falling_edge_active(falling_edge_active), .isr_start(isr_start), .isr_vector(isr_vector)
);
`default_nettype wire

// ### dv/counter_capture_on_interrupt_tb.sv
// Self-checking bench for the counter capture block
`timescale 1ns/1ps
`default_nettype none

module counter_capture_on_interrupt_tb
  import capture_pkg::*;
;
  logic        clk = 1'b0, reset_n = 1'b0, flag = 1'b0, en_op = 1'b0, dis_op = 1'b0;
  logic        a_run = 1'b0, b_run = 1'b0, ad, bd, ie, fa, isr;
  logic [4:0]  ven = 5'h00;
  logic [1:0]  a_sel = 2'h0, b_sel = 2'h3;
  wire  [5:0]  pins;
  logic [15:0] cah, cal, cbh, cbl;
  logic [31:0] ca, cb;
  isr_vector_t vec;
  int          mismatches = 0, samples_checked = 0;

  always #10 clk = ~clk;

  field_pins pins_m (.clk(clk), .pins(pins));

  counter_capture_on_interrupt dut
  (
    .clk(clk), .reset_n(reset_n), .input_point_zero(pins[0]), .input_point_one(pins[1]),
    .input_point_two(pins[2]), .input_point_three(pins[3]), .input_point_four(pins[4]),
    .input_point_five(pins[5]), .edge_reverse_flag(flag), .interrupt_enable_op(en_op),
    .interrupt_disable_op(dis_op), .vector_enable(ven), .counter_a_run(a_run),
    .counter_a_select(a_sel), .counter_b_run(b_run), .counter_b_select(b_sel),
    .capture_a_high(cah), .capture_a_low(cal), .capture_b_high(cbh), .capture_b_low(cbl),
    .count_a(ca), .count_b(cb), .capture_a_done(ad), .capture_b_done(bd),
    .interrupts_enabled(ie), .falling_edge_active(fa), .isr_start(isr), .isr_vector(vec)
  );

  task automatic complete_run();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("FAIL %0t got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask

  task automatic chk_vec(input isr_vector_t got, input isr_vector_t exp);
    chk32({26'h0, got}, {26'h0, exp});
  endtask

  // The done pulse in the cycle just before the routine starts must match exp_done
  task automatic wait_isr(input isr_vector_t exp, input logic exp_done);
    logic done_seen;
    done_seen = 1'b0;
    for (int i = 0; i < 20; i++)
    begin
      @(negedge clk);
      if (isr === 1'b1)
      begin
        chk_vec(vec, exp);
        chk32({31'h0, done_seen}, {31'h0, exp_done});
        return;
      end
      done_seen = ad | bd;
    end
    $display("FAIL %0t routine never started", $time);
    mismatches++;
    complete_run();
  endtask

  task automatic enable_op();
    @(negedge clk) en_op = 1'b1;
    @(negedge clk) en_op = 1'b0;
    chk32({31'h0, fa}, {31'h0, flag});
    chk32({31'h0, ie}, 32'h0000_0001);
  endtask

  task automatic t_pair_a();
    a_run = 1'b1;
    pins_m.pulse(0, 3);
    pins_m.pulse(1, 1);
    chk32(ca, 32'h0000_0000);
    chk32({cah, cal}, 32'h0000_0000);
    ven = 5'h02;
    enable_op();
    pins_m.pulse(0, 5);
    fork
      pins_m.pulse(1, 1);
      wait_isr(PIN1_INTERRUPT_VECTOR, 1'b1);
    join
    chk32({cah, cal}, 32'h0000_0005);
    chk32(ca, 32'h0000_0000);
    $display("test pair_a done");
  endtask

  task automatic t_pairs();
    for (int s = 1; s < 4; s++)
    begin
      a_sel = s[1:0];
      ven = 5'h08;
      pins_m.pulse(0, s);
      fork
        pins_m.pulse(4, 1);
        wait_isr(PIN4_INTERRUPT_VECTOR, 1'b1);
      join
      chk32({cah, cal}, s);
    end
    b_run = 1'b1;
    for (int s = 0; s < 3; s++)
    begin
      b_sel = s[1:0];
      ven = (s == 0) ? 5'h04 : 5'h10;
      pins_m.pulse(2, s + 2);
      fork
        pins_m.pulse((s == 0) ? 3 : 5, 1);
        wait_isr((s == 0) ? PIN3_INTERRUPT_VECTOR : PIN5_INTERRUPT_VECTOR, 1'b1);
      join
      chk32({cbh, cbl}, s + 2);
      chk32(cb, 32'h0000_0000);
    end
    $display("test pairs done");
  endtask

  task automatic t_reverse();
    a_run = 1'b0;
    ven = 5'h01;
    flag = 1'b1;
    enable_op();
    fork
      pins_m.pulse(0, 1);
      wait_isr(PIN0_FALLING_VECTOR, 1'b0);
    join
    flag = 1'b0;
    repeat (2) @(negedge clk);
    chk32({31'h0, fa}, 32'h0000_0000);
    fork
      pins_m.pulse(0, 1);
      wait_isr(PIN0_INTERRUPT_VECTOR, 1'b0);
    join
    $display("test reverse done");
  endtask

  // Disabled interrupts: the paired pin only clears, and the flag alone changes nothing
  task automatic t_disable();
    logic seen;
    seen  = 1'b0;
    a_sel = 2'h0;
    a_run = 1'b1;
    ven   = 5'h02;
    pins_m.pulse(0, 2);
    chk32(ca, 32'h0000_0002);
    @(negedge clk) dis_op = 1'b1;
    @(negedge clk) dis_op = 1'b0;
    chk32({31'h0, ie}, 32'h0000_0000);
    flag = 1'b1;
    repeat (2) @(negedge clk);
    chk32({31'h0, fa}, 32'h0000_0000);
    flag = 1'b0;
    fork
      pins_m.pulse(1, 1);
      for (int i = 0; i < 8; i++)
      begin
        @(negedge clk);
        seen = seen | isr;
      end
    join
    chk32({31'h0, seen}, 32'h0000_0000);
    chk32({cah, cal}, 32'h0000_0003);
    chk32(ca, 32'h0000_0000);
    $display("test disable done");
  endtask

  initial
  begin
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    t_pair_a();
    t_pairs();
    t_reverse();
    t_disable();
    complete_run();
  end
endmodule
`default_nettype wire

// ### dv/field_pins.sv
// Field-side model driving the six input points
`timescale 1ns/1ps
`default_nettype none

module field_pins
(
  input  wire logic       clk,
  output var  logic [5:0] pins
);
  initial pins = 6'h00;

  // Three cycles each level, so every edge clears the agreement filter
  task automatic pulse(input int idx, input int n);
    repeat (n)
    begin
      @(negedge clk) pins[idx] = 1'b1;
      repeat (3) @(negedge clk);
      pins[idx] = 1'b0;
      repeat (3) @(negedge clk);
    end
  endtask
endmodule
`default_nettype wire

// ### logic/capture_params.svh
// Constants for the counter capture block
`ifndef CAPTURE_PARAMS_SVH
`define CAPTURE_PARAMS_SVH

`define COUNT_W        32
`define WORD_W         16
`define SEL_W          2
`define EN_W           5
`define PEND_W         6

// Counter selection codes, group a (counted pin zero)
`define SEL_A0         2'h0
// Counter selection codes, group b (counted pin two)
`define SEL_B0         2'h0
`define SEL_B1         2'h1
`define SEL_B2         2'h2

// Interrupt source enable bit positions
`define EN_P0          0
`define EN_P1          1
`define EN_P3          2
`define EN_P4          3
`define EN_P5          4

// Pending bit positions, equal to the vector code bit positions
`define PB_P0R         0
`define PB_P0F         1
`define PB_P1          2
`define PB_P3          3
`define PB_P4          4
`define PB_P5          5

`endif

// ### logic/capture_pkg.sv
// Types shared by the counter capture block
package capture_pkg;

  typedef enum logic [5:0]
  {
    VEC_NONE             = 6'h00,
    PIN0_INTERRUPT_VECTOR = 6'h01,
    PIN0_FALLING_VECTOR  = 6'h02,
    PIN1_INTERRUPT_VECTOR = 6'h04,
    PIN3_INTERRUPT_VECTOR = 6'h08,
    PIN4_INTERRUPT_VECTOR = 6'h10,
    PIN5_INTERRUPT_VECTOR = 6'h20
  } isr_vector_t;

endpackage

// ### logic/counter_capture_on_interrupt.sv
// Counter capture on external interrupt, with pin zero edge reversal
`timescale 1ns/1ps
`default_nettype none
`include "capture_params.svh"

// Behaviour
// - Pin zero interrupt fires on rising edge; falling if flag set at enable.
// - Clearing the edge-reverse flag returns pin zero to rising-edge triggering.
// - A pin that is both counter reset and interrupt acts as interrupt.
// - On the interrupt, copy the counter value first, then clear the counter.
// - Group a counter zero, paired with pin one, captures into pair a.
// - Group a counters one to three, paired with pin four, capture into pair a.
// - Group b counter zero, paired with pin three, captures into pair b.
// - Group b counters one and two, paired with pin five, capture into pair b.
// - After store and clear, start the service routine of the firing pin.
module counter_capture_on_interrupt
  import capture_pkg::*;
#(
  parameter int COUNT_W = `COUNT_W,
  parameter int WORD_W  = `WORD_W
)
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              input_point_zero,
  input  wire logic              input_point_one,
  input  wire logic              input_point_two,
  input  wire logic              input_point_three,
  input  wire logic              input_point_four,
  input  wire logic              input_point_five,
  input  wire logic              edge_reverse_flag,
  input  wire logic              interrupt_enable_op,
  input  wire logic              interrupt_disable_op,
  input  wire logic [`EN_W-1:0]  vector_enable,
  input  wire logic              counter_a_run,
  input  wire logic [`SEL_W-1:0] counter_a_select,
  input  wire logic              counter_b_run,
  input  wire logic [`SEL_W-1:0] counter_b_select,
  output var  logic [WORD_W-1:0] capture_a_high,
  output var  logic [WORD_W-1:0] capture_a_low,
  output var  logic [WORD_W-1:0] capture_b_high,
  output var  logic [WORD_W-1:0] capture_b_low,
  output var  logic [COUNT_W-1:0] count_a,
  output var  logic [COUNT_W-1:0] count_b,
  output var  logic              capture_a_done,
  output var  logic              capture_b_done,
  output var  logic              interrupts_enabled,
  output var  logic              falling_edge_active,
  output var  logic              isr_start,
  output var  isr_vector_t       isr_vector
);

  if (COUNT_W != 2 * WORD_W)
  begin : g_width_check
    $error("COUNT_W must be twice WORD_W");
  end

  localparam logic [COUNT_W-1:0] COUNT_ONE = COUNT_W'(1);

  logic [5:0] rise;
  logic [5:0] fall;
  logic [5:0] pins;

  assign pins = {input_point_five, input_point_four, input_point_three,
                 input_point_two, input_point_one, input_point_zero};

  genvar gi;
  for (gi = 0; gi < 6; gi++)
  begin : g_pin
    pin_filter u_filter
    (
      .clk     (clk),
      .reset_n (reset_n),
      .pin     (pins[gi]),
      .rise_q  (rise[gi]),
      .fall_q  (fall[gi])
    );
  end

  // Enable and polarity state
  logic int_en_q;
  logic int_en_d;
  logic pol_q;
  logic pol_d;

  always_comb
  begin
    int_en_d = int_en_q;
    pol_d    = pol_q;
    if (interrupt_disable_op)
    begin
      int_en_d = 1'b0;
    end
    else if (interrupt_enable_op)
    begin
      int_en_d = 1'b1;
    end
    // Polarity is latched only by the enable operation, so the flag must lead it
    if (interrupt_enable_op && edge_reverse_flag)
    begin
      pol_d = 1'b1;
    end
    if (!edge_reverse_flag)
    begin
      pol_d = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      int_en_q <= 1'b0;
      pol_q    <= 1'b0;
    end
    else
    begin
      int_en_q <= int_en_d;
      pol_q    <= pol_d;
    end
  end

  // Interrupt events per source
  logic [`PEND_W-1:0] ev;
  logic               a_pin_edge;
  logic               a_pin_armed;
  logic               b_pin_edge;
  logic               b_pin_armed;
  logic               b_valid;

  always_comb
  begin
    ev = '0;
    ev[`PB_P0R] = int_en_q & vector_enable[`EN_P0] & ~pol_q & rise[0];
    ev[`PB_P0F] = int_en_q & vector_enable[`EN_P0] & pol_q & fall[0];
    ev[`PB_P1]  = int_en_q & vector_enable[`EN_P1] & rise[1];
    ev[`PB_P3]  = int_en_q & vector_enable[`EN_P3] & rise[3];
    ev[`PB_P4]  = int_en_q & vector_enable[`EN_P4] & rise[4];
    ev[`PB_P5]  = int_en_q & vector_enable[`EN_P5] & rise[5];
    if (counter_a_select == `SEL_A0)
    begin
      a_pin_edge  = rise[1];
      a_pin_armed = int_en_q & vector_enable[`EN_P1];
    end
    else
    begin
      a_pin_edge  = rise[4];
      a_pin_armed = int_en_q & vector_enable[`EN_P4];
    end
    b_valid = 1'b1;
    if (counter_b_select == `SEL_B0)
    begin
      b_pin_edge  = rise[3];
      b_pin_armed = int_en_q & vector_enable[`EN_P3];
    end
    else if (counter_b_select == `SEL_B1 || counter_b_select == `SEL_B2)
    begin
      b_pin_edge  = rise[5];
      b_pin_armed = int_en_q & vector_enable[`EN_P5];
    end
    else
    begin
      b_pin_edge  = 1'b0;
      b_pin_armed = 1'b0;
      b_valid     = 1'b0;
    end
  end

  // Counters and capture pairs
  logic [COUNT_W-1:0] cnt_a_d;
  logic [COUNT_W-1:0] cnt_b_d;
  logic [COUNT_W-1:0] cap_a_d;
  logic [COUNT_W-1:0] cap_b_d;
  logic [COUNT_W-1:0] cap_a_q;
  logic [COUNT_W-1:0] cap_b_q;
  logic               take_a;
  logic               take_b;

  always_comb
  begin
    take_a  = counter_a_run & a_pin_edge & a_pin_armed;
    take_b  = counter_b_run & b_valid & b_pin_edge & b_pin_armed;
    cnt_a_d = count_a;
    cnt_b_d = count_b;
    cap_a_d = cap_a_q;
    cap_b_d = cap_b_q;
    if (take_a)
    begin
      cap_a_d = count_a;
    end
    if (take_b)
    begin
      cap_b_d = count_b;
    end
    // Unarmed pin acts as a plain counter reset; armed pin goes to the interrupt
    if (counter_a_run && a_pin_edge)
    begin
      cnt_a_d = '0;
    end
    if (counter_b_run && b_valid && b_pin_edge)
    begin
      cnt_b_d = '0;
    end
    // A count edge in the clearing cycle is kept rather than lost
    if (counter_a_run && rise[0])
    begin
      cnt_a_d = cnt_a_d + COUNT_ONE;
    end
    if (counter_b_run && b_valid && rise[2])
    begin
      cnt_b_d = cnt_b_d + COUNT_ONE;
    end
  end

  // Pending interrupts and service start
  logic [`PEND_W-1:0] pend_q;
  logic [`PEND_W-1:0] pend_d;
  logic [`PEND_W-1:0] pick;
  logic               start_d;

  always_comb
  begin
    pick    = pend_q & (~pend_q + `PEND_W'(1));
    start_d = |pick;
    // New events are OR-ed after the service clear so a set never gets lost
    pend_d  = (pend_q & ~pick) | ev;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      count_a        <= '0;
      count_b        <= '0;
      cap_a_q        <= '0;
      cap_b_q        <= '0;
      capture_a_done <= 1'b0;
      capture_b_done <= 1'b0;
      pend_q         <= '0;
      isr_start      <= 1'b0;
      isr_vector     <= VEC_NONE;
    end
    else
    begin
      count_a        <= cnt_a_d;
      count_b        <= cnt_b_d;
      cap_a_q        <= cap_a_d;
      cap_b_q        <= cap_b_d;
      capture_a_done <= take_a;
      capture_b_done <= take_b;
      pend_q         <= pend_d;
      isr_start      <= start_d;
      isr_vector     <= isr_vector_t'(pick);
    end
  end

  assign capture_a_high      = cap_a_q[COUNT_W-1:WORD_W];
  assign capture_a_low       = cap_a_q[WORD_W-1:0];
  assign capture_b_high      = cap_b_q[COUNT_W-1:WORD_W];
  assign capture_b_low       = cap_b_q[WORD_W-1:0];
  assign interrupts_enabled  = int_en_q;
  assign falling_edge_active = pol_q;

endmodule

`default_nettype wire

// ### logic/pin_filter.sv
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`default_nettype none

module pin_filter
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic pin,
  output var  logic rise_q,
  output var  logic fall_q
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;
  logic level_d;
  logic rise_d;
  logic fall_d;

  // Only the second stage reads s1_q; the filter looks at stages two and three
  always_comb
  begin
    level_d = level_q;
    if (s2_q == s3_q)
    begin
      level_d = s3_q;
    end
    rise_d = level_d & ~level_q;
    fall_d = ~level_d & level_q;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_q <= 1'b0;
      rise_q  <= 1'b0;
      fall_q  <= 1'b0;
    end
    else
    begin
      s1_q    <= pin;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      level_q <= level_d;
      rise_q  <= rise_d;
      fall_q  <= fall_d;
    end
  end

endmodule

`default_nettype wire
